// ==== design/dma_crc_chan.sv ====
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module dma_crc_chan
	import dma_crc_pkg::*;
(
	input  wire logic                           clk,
	input  wire logic                           rst_n,
	input  wire logic [dma_crc_pkg::ADDR_W-1:0] addr,
	input  wire logic [31:0]                    wdata,
	input  wire logic                           wr,
	input  wire logic                           rd,
	output logic      [31:0]                    rdata,
	input  wire logic                           err_read_valid,
	input  wire logic [31:0]                    err_read_addr,
	input  wire logic                           err_write_valid,
	input  wire logic [31:0]                    err_write_addr,
	input  wire logic                           beat_valid,
	input  wire logic [2:0]                     beat_channel,
	input  wire logic [31:0]                    beat_data,
	input  wire logic                           beat_last,
	input  wire logic [31:0]                    beat_dest_addr,
	input  wire logic                           beat_pattern_en,
	input  wire logic [15:0]                    beat_pattern,
	output logic                                out_valid,
	output logic                                out_write,
	output logic      [31:0]                    out_data,
	output logic                                append_valid,
	output logic      [31:0]                    append_addr,
	output logic      [31:0]                    append_data,
	output logic                                pattern_hit,
	input  wire logic [7:0]                     block_done,
	input  wire logic [7:0]                     chan_active,
	input  wire logic [7:0]                     start_event,
	input  wire logic [7:0]                     abort_event,
	output logic      [7:0]                     start_take,
	output logic      [7:0]                     abort_take,
	output logic      [7:0]                     channel_enable,
	output logic      [15:0]                    channel_priority,
	input  wire logic [7:0]                     chan_request,
	output logic                                grant_valid,
	output logic      [2:0]                     grant_channel
);
	import dma_crc_pkg::*;

	typedef struct packed {
		logic [31:0]     rdata;
		logic [31:0]     err_addr;
		logic            err_locked;
		logic [1:0]      byte_order;
		logic            write_reorder;
		logic            bit_reflect;
		logic [4:0]      poly_len;
		logic            crc_en;
		logic            append;
		logic            ip_mode;
		logic [2:0]      crc_ch;
		logic [31:0]     crc;
		logic [31:0]     taps;
		logic [7:0][7:0] ign_val;
		logic [7:0]      ign_en;
		logic [7:0]      pat_len;
		logic [7:0]      chain_dir;
		logic [7:0]      chan_en;
		logic [7:0]      ev_dis;
		logic [7:0]      chain_ok;
		logic [7:0]      auto_en;
		logic [7:0]      ev_seen;
		logic [7:0][1:0] prio;
		logic            out_valid;
		logic            out_write;
		logic [31:0]     out_data;
		logic            app_valid;
		logic [31:0]     app_addr;
		logic [31:0]     app_data;
		logic            hit;
		logic [7:0]      start_take;
		logic [7:0]      abort_take;
		logic            grant_valid;
		logic [2:0]      grant_ch;
	} state_t;

	state_t s;
	state_t next_s;

	function automatic logic [31:0] reorder(input logic [31:0] d, input logic [1:0] order);
		unique case (order)
			ORDER_NONE: reorder = d;
			ORDER_WORD: reorder = {d[7:0], d[15:8], d[23:16], d[31:24]};
			ORDER_HALF: reorder = {d[15:0], d[31:16]};
			ORDER_BYTE: reorder = {d[23:16], d[31:24], d[7:0], d[15:8]};
		endcase
	endfunction

	function automatic logic [31:0] len_mask(input logic [4:0] len_m1);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < 32; i++)
		begin
			m[i] = (5'(i) <= len_m1);
		end
		return m;
	endfunction

	// Serial shift of one word, taps gate the feedback into each stage.
	function automatic logic [31:0] lfsr_step(input logic [31:0] c, input logic [31:0] d,
		input logic [31:0] taps, input logic [4:0] len_m1, input logic refl);
		logic [31:0] r;
		logic        bit_in;
		logic        fb;
		r = c;
		for (int i = 0; i < 32; i++)
		begin
			bit_in = refl ? d[i] : d[31-i];
			fb = r[len_m1] ^ bit_in;
			r = ((r << 1) ^ (taps & {32{fb}})) & len_mask(len_m1);
		end
		return r;
	endfunction

	function automatic logic [15:0] ones_add(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] t;
		t = {1'b0, a} + {1'b0, b};
		return t[15:0] + {15'h0000, t[16]};
	endfunction

	function automatic logic [15:0] rev16(input logic [15:0] v);
		logic [15:0] r;
		r = '0;
		for (int i = 0; i < 16; i++)
		begin
			r[i] = v[15-i];
		end
		return r;
	endfunction

	function automatic logic [31:0] crc_view(input logic [31:0] c, input logic ip, input logic [4:0] len_m1);
		if (ip)
			return {16'h0000, ~c[15:0]};
		return c & len_mask(len_m1);
	endfunction

	function automatic logic byte_ok(input logic [7:0] d, input logic [7:0] p,
		input logic ign, input logic [7:0] iv);
		return (d == p) || (ign && (d == iv));
	endfunction

	function automatic logic [3:0] chan_slot(input logic [ADDR_W-1:0] a);
		return a[7:4] - CHAN_BASE_IDX;
	endfunction

	function automatic logic chan_hit(input logic [ADDR_W-1:0] a);
		return (a[3:0] == 4'h0) && (a[7:4] >= CHAN_BASE_IDX) && (chan_slot(a) < 4'(CHANNELS));
	endfunction

	logic [31:0] reordered;
	logic        crc_on;
	logic [31:0] crc_next;
	logic [15:0] ip_hi;
	logic [15:0] ip_lo;
	logic        hit_now;
	logic [7:0]  done_vec;
	logic [31:0] chan_word;
	logic [2:0]  ch_idx;
	logic [1:0]  best_prio;
	logic        err_clear;

	always_comb
	begin
		next_s = s;
		next_s.out_valid = 1'b0;
		next_s.app_valid = 1'b0;
		next_s.hit = 1'b0;
		next_s.start_take = '0;
		next_s.abort_take = '0;
		ch_idx = 3'(chan_slot(addr));
		chan_word = '0;
		best_prio = '0;

		// A read of the error address empties it, but a new error in the same cycle is kept.
		err_clear = rd && ((addr == ERR_ADDR_OFS) || (addr == ERR_ALIAS_OFS));
		if (err_clear)
		begin
			next_s.err_addr = ERR_ADDR_RESET;
			next_s.err_locked = 1'b0;
		end
		if (!s.err_locked || err_clear)
		begin
			if (err_read_valid)
			begin
				next_s.err_addr = err_read_addr;
				next_s.err_locked = 1'b1;
			end
			else if (err_write_valid)
			begin
				next_s.err_addr = err_write_addr;
				next_s.err_locked = 1'b1;
			end
		end

		reordered = reorder(beat_data, s.byte_order);
		crc_on = s.crc_en && (beat_channel == s.crc_ch);
		ip_hi = s.bit_reflect ? rev16(reordered[31:16]) : reordered[31:16];
		ip_lo = s.bit_reflect ? rev16(reordered[15:0]) : reordered[15:0];
		if (s.ip_mode)
			crc_next = {16'h0000, ones_add(ones_add(s.crc[15:0], ip_hi), ip_lo)};
		else
			crc_next = lfsr_step(s.crc, reordered, s.taps, s.poly_len, s.bit_reflect);

		hit_now = beat_valid && beat_pattern_en
			&& byte_ok(beat_data[7:0], beat_pattern[7:0], s.ign_en[beat_channel], s.ign_val[beat_channel])
			&& (!s.pat_len[beat_channel]
			|| byte_ok(beat_data[15:8], beat_pattern[15:8], s.ign_en[beat_channel], s.ign_val[beat_channel]));
		next_s.hit = hit_now;
		done_vec = block_done | (hit_now ? (8'h01 << beat_channel) : 8'h00);

		if (beat_valid)
		begin
			next_s.out_valid = 1'b1;
			next_s.out_write = !(crc_on && s.append);
			next_s.out_data = (crc_on && s.write_reorder) ? reordered : beat_data;
			if (crc_on)
			begin
				next_s.crc = crc_next;
				if (s.append && (beat_last || hit_now))
				begin
					next_s.app_valid = 1'b1;
					next_s.app_addr = beat_dest_addr;
					next_s.app_data = crc_view(crc_next, s.ip_mode, s.poly_len);
				end
			end
		end

		if (wr)
		begin
			unique case (addr)
				CRC_CTRL_OFS:
				begin
					next_s.byte_order = wdata[BYTE_ORDER_LSB +: 2];
					next_s.write_reorder = wdata[WRITE_REORDER_B];
					next_s.bit_reflect = wdata[BIT_REFLECT_B];
					next_s.poly_len = wdata[POLY_LEN_LSB +: 5];
					next_s.crc_en = wdata[CRC_ENABLE_B];
					next_s.append = wdata[CRC_APPEND_B] && !wdata[WRITE_REORDER_B];
					next_s.ip_mode = wdata[CRC_TYPE_B];
					next_s.crc_ch = wdata[CRC_CHAN_LSB +: 3];
				end
				CRC_VALUE_OFS:
				begin
					// The seed is stored in the form the engine accumulates in.
					if (s.ip_mode)
						next_s.crc = {16'h0000, ~wdata[15:0]};
					else
						next_s.crc = wdata & len_mask(s.poly_len);
				end
				CRC_TAPS_OFS:
					next_s.taps = wdata;
				default:
				begin
					if (chan_hit(addr))
					begin
						next_s.ign_val[ch_idx] = wdata[IGNORE_VAL_LSB +: 8];
						next_s.ign_en[ch_idx] = wdata[IGNORE_EN_B];
						next_s.pat_len[ch_idx] = wdata[PAT_LEN_B];
						next_s.chain_dir[ch_idx] = wdata[CHAIN_DIR_B];
						next_s.chan_en[ch_idx] = wdata[CHAN_EN_B];
						next_s.ev_dis[ch_idx] = wdata[EV_DIS_B];
						next_s.chain_ok[ch_idx] = wdata[CHAIN_OK_B];
						next_s.auto_en[ch_idx] = wdata[AUTO_EN_B];
						next_s.ev_seen[ch_idx] = 1'b0;
						next_s.prio[ch_idx] = wdata[PRIO_LSB +: 2];
					end
				end
			endcase
		end

		for (int i = 0; i < CHANNELS; i++)
		begin
			if (done_vec[i] && !s.auto_en[i])
				next_s.chan_en[i] = 1'b0;
			// Chained start outranks the completion clear of the same channel.
			if (s.chain_ok[i])
			begin
				if (s.chain_dir[i] && (i < CHANNELS - 1) && done_vec[(i + 1) % CHANNELS])
					next_s.chan_en[i] = 1'b1;
				if (!s.chain_dir[i] && (i > 0) && done_vec[(i + CHANNELS - 1) % CHANNELS])
					next_s.chan_en[i] = 1'b1;
			end
			next_s.start_take[i] = start_event[i] && (s.chan_en[i] || s.ev_dis[i]);
			next_s.abort_take[i] = abort_event[i] && (s.chan_en[i] || s.ev_dis[i]);
			if (next_s.start_take[i] || next_s.abort_take[i])
				next_s.ev_seen[i] = 1'b1;
		end

		// Highest priority wins; among equals the lower channel number.
		next_s.grant_valid = 1'b0;
		next_s.grant_ch = '0;
		for (int i = CHANNELS - 1; i >= 0; i--)
		begin
			if (chan_request[i] && s.chan_en[i] && (!next_s.grant_valid || s.prio[i] >= best_prio))
			begin
				next_s.grant_valid = 1'b1;
				next_s.grant_ch = 3'(i);
				best_prio = s.prio[i];
			end
		end

		if (chan_hit(addr))
		begin
			chan_word[IGNORE_VAL_LSB +: 8] = s.ign_val[ch_idx];
			chan_word[CHAN_BUSY_B] = s.chan_en[ch_idx] || chan_active[ch_idx];
			chan_word[IGNORE_EN_B] = s.ign_en[ch_idx];
			chan_word[PAT_LEN_B] = s.pat_len[ch_idx];
			chan_word[CHAIN_DIR_B] = s.chain_dir[ch_idx];
			chan_word[CHAN_EN_B] = s.chan_en[ch_idx];
			chan_word[EV_DIS_B] = s.ev_dis[ch_idx];
			chan_word[CHAIN_OK_B] = s.chain_ok[ch_idx];
			chan_word[AUTO_EN_B] = s.auto_en[ch_idx];
			chan_word[EV_SEEN_B] = s.ev_seen[ch_idx];
			chan_word[PRIO_LSB +: 2] = s.prio[ch_idx];
		end

		next_s.rdata = '0;
		if (rd)
		begin
			unique case (addr)
				ERR_ADDR_OFS, ERR_ALIAS_OFS:
					next_s.rdata = s.err_addr;
				CRC_CTRL_OFS:
				begin
					next_s.rdata[BYTE_ORDER_LSB +: 2] = s.byte_order;
					next_s.rdata[WRITE_REORDER_B] = s.write_reorder;
					next_s.rdata[BIT_REFLECT_B] = s.bit_reflect;
					next_s.rdata[POLY_LEN_LSB +: 5] = s.poly_len;
					next_s.rdata[CRC_ENABLE_B] = s.crc_en;
					next_s.rdata[CRC_APPEND_B] = s.append;
					next_s.rdata[CRC_TYPE_B] = s.ip_mode;
					next_s.rdata[CRC_CHAN_LSB +: 3] = s.crc_ch;
				end
				CRC_VALUE_OFS:
					next_s.rdata = crc_view(s.crc, s.ip_mode, s.poly_len);
				CRC_TAPS_OFS:
					next_s.rdata = s.taps;
				default:
					next_s.rdata = chan_word;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s <= '0;
			s.err_addr <= ERR_ADDR_RESET;
			s.crc <= CRC_VALUE_RESET;
			s.taps <= CRC_TAPS_RESET;
		end
		else
			s <= next_s;
	end

	assign rdata = s.rdata;
	assign out_valid = s.out_valid;
	assign out_write = s.out_write;
	assign out_data = s.out_data;
	assign append_valid = s.app_valid;
	assign append_addr = s.app_addr;
	assign append_data = s.app_data;
	assign pattern_hit = s.hit;
	assign start_take = s.start_take;
	assign abort_take = s.abort_take;
	assign channel_enable = s.chan_en;
	assign channel_priority = s.prio;
	assign grant_valid = s.grant_valid;
	assign grant_channel = s.grant_ch;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	err_capture_a: assert property (!s.err_locked && err_read_valid |=> s.err_addr == $past(err_read_addr))
		else $error("error address not captured");
	err_hold_a: assert property (s.err_locked && !(rd && (addr == ERR_ADDR_OFS || addr == ERR_ALIAS_OFS))
		|=> $stable(s.err_addr) && s.err_locked)
		else $error("locked error address changed");
	append_block_a: assert property (wr && addr == CRC_CTRL_OFS && wdata[WRITE_REORDER_B] |=> !s.append)
		else $error("append set while reordering");
	dest_pass_a: assert property (beat_valid && !(s.crc_en && beat_channel == s.crc_ch)
		|=> out_valid && out_write && out_data == $past(beat_data))
		else $error("non-crc channel data altered");
	append_quiet_a: assert property (beat_valid && s.crc_en && s.append && beat_channel == s.crc_ch
		|=> out_valid && !out_write)
		else $error("append mode wrote source data");
	raw_write_a: assert property (beat_valid && s.crc_en && !s.write_reorder && beat_channel == s.crc_ch
		|=> out_data == $past(beat_data))
		else $error("data reordered without write-reorder");
	busy_read_a: assert property (rd && addr == {CHAN_BASE_IDX, 4'h0}
		|=> rdata[CHAN_BUSY_B] == $past(s.chan_en[0] || chan_active[0]))
		else $error("busy bit wrong");
	auto_clear_a: assert property (block_done[0] && !s.auto_en[0] && !s.chain_ok[0] && !wr |=> !channel_enable[0])
		else $error("channel not disabled at completion");
	ip_upper_a: assert property (rd && addr == CRC_VALUE_OFS && s.ip_mode |=> rdata[31:16] == 16'h0000)
		else $error("ip upper bits nonzero");
	event_gate_a: assert property (start_event[5] && !s.chan_en[5] && !s.ev_dis[5] |=> !start_take[5])
		else $error("event taken on disabled channel");

	append_cov: cover property (append_valid);
	hit_cov: cover property (pattern_hit && append_valid);
	chain_cov: cover property (block_done[0] && s.chain_ok[1] && !s.chain_dir[1] ##1 channel_enable[1]);
	err_cov: cover property (err_read_valid && err_write_valid);
endmodule
`default_nettype wire

// ==== design/dma_crc_pkg.sv ====
// Operation
// - Bus error captures full 32-bit access address.
// - Error address clears on read; holds first error.
// - Byte order field selects four reorderings.
// - Write-reorder bit reorders destination data.
// - Bit-order bit selects LSb-first computation.
// - Polynomial length field ignored in IP mode.
// - CRC enable routes assigned channel through engine.
// - Append mode writes CRC to destination start.
// - Type bit selects IP checksum or LFSR.
// - Channel select assigns engine to one channel.
// - CRC value write seeds; read masked by length.
// - IP mode reads ones-complement low sixteen bits.
// - Feedback taps select XOR per shift stage.
// - Ignore byte is don't-care in pattern match.
// - Pattern length bit selects one or two bytes.
// - Chained channel enabled by neighbour completion.
// - Busy reads one while active or enabled.
// - Events while disabled registered only if allowed.
// - Without auto-enable, completion clears channel enable.
// - Two-bit priority, three highest, arbitrates channels.
// - Completion is block end or pattern match.
`default_nettype none
package dma_crc_pkg;
	localparam int          ADDR_W          = 8;
	localparam logic [7:0]  ERR_ADDR_OFS    = 8'h00;
	localparam logic [7:0]  ERR_ALIAS_OFS   = 8'h04;
	localparam logic [7:0]  CRC_CTRL_OFS    = 8'h10;
	localparam logic [7:0]  CRC_VALUE_OFS   = 8'h20;
	localparam logic [7:0]  CRC_TAPS_OFS    = 8'h30;
	localparam logic [3:0]  CHAN_BASE_IDX   = 4'h4;
	localparam int          CHANNELS        = 8;
	localparam logic [31:0] ERR_ADDR_RESET  = 32'h00000000;
	localparam logic [31:0] CRC_CTRL_RESET  = 32'h00000000;
	localparam logic [31:0] CRC_VALUE_RESET = 32'h00000000;
	localparam logic [31:0] CRC_TAPS_RESET  = 32'h00000000;
	localparam logic [31:0] CHAN_CTRL_RESET = 32'h00000000;
	localparam int BYTE_ORDER_LSB  = 28;
	localparam int WRITE_REORDER_B = 27;
	localparam int BIT_REFLECT_B   = 24;
	localparam int POLY_LEN_LSB    = 8;
	localparam int CRC_ENABLE_B    = 7;
	localparam int CRC_APPEND_B    = 6;
	localparam int CRC_TYPE_B      = 5;
	localparam int CRC_CHAN_LSB    = 0;
	localparam int IGNORE_VAL_LSB  = 24;
	localparam int CHAN_BUSY_B     = 15;
	localparam int IGNORE_EN_B     = 13;
	localparam int PAT_LEN_B       = 11;
	localparam int CHAIN_DIR_B     = 8;
	localparam int CHAN_EN_B       = 7;
	localparam int EV_DIS_B        = 6;
	localparam int CHAIN_OK_B      = 5;
	localparam int AUTO_EN_B       = 4;
	localparam int EV_SEEN_B       = 2;
	localparam int PRIO_LSB        = 0;
	localparam logic [1:0] ORDER_NONE = 2'h0;
	localparam logic [1:0] ORDER_WORD = 2'h1;
	localparam logic [1:0] ORDER_HALF = 2'h2;
	localparam logic [1:0] ORDER_BYTE = 2'h3;
endpackage
`default_nettype wire

// ==== verification/dest_memory.sv ====
`timescale 1ns/1ps
`default_nettype none
module dest_memory
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        out_valid,
	input  wire logic        out_write,
	input  wire logic [31:0] out_data,
	input  wire logic        append_valid,
	input  wire logic [31:0] append_addr,
	input  wire logic [31:0] append_data,
	output logic      [7:0]  write_count,
	output logic      [31:0] last_word,
	output logic      [31:0] app_addr,
	output logic      [31:0] app_data
);
	// Stands for the destination memory: it counts stored words and keeps the appended result.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			write_count <= '0;
			last_word   <= '0;
			app_addr    <= '0;
			app_data    <= '0;
		end
		else
		begin
			if (out_valid && out_write)
			begin
				write_count <= write_count + 8'h01;
				last_word   <= out_data;
			end
			if (append_valid)
			begin
				app_addr <= append_addr;
				app_data <= append_data;
			end
		end
	end
endmodule
`default_nettype wire

// ==== verification/dma_crc_and_channel_control_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module dma_crc_and_channel_control_bench;
	import dma_crc_pkg::*;
	localparam logic [31:0] TAPS = 32'h0000_0007;
	localparam logic [31:0] D    = 32'h1122_3344;
	localparam logic [31:0] DEST = 32'h2000_0100;
	logic              clk             = 1'b0;
	logic              rst_n           = 1'b0;
	logic [ADDR_W-1:0] addr            = '0;
	logic [31:0]       wdata           = '0;
	logic              wr              = 1'b0;
	logic              rd              = 1'b0;
	logic              err_read_valid  = 1'b0;
	logic [31:0]       err_read_addr   = 32'hA000_0010;
	logic              err_write_valid = 1'b0;
	logic [31:0]       err_write_addr  = 32'hB000_0020;
	logic              beat_valid      = 1'b0;
	logic [2:0]        beat_channel    = '0;
	logic [31:0]       beat_data       = '0;
	logic              beat_last       = 1'b0;
	logic              beat_pattern_en = 1'b0;
	logic [15:0]       beat_pattern    = 16'hAA55;
	logic [7:0]        block_done      = '0;
	logic [7:0]        chan_active     = '0;
	logic [7:0]        start_event     = '0;
	logic [7:0]        abort_event     = '0;
	logic [7:0]        chan_request    = '0;
	logic [31:0]       rdata;
	logic              out_valid;
	logic              out_write;
	logic [31:0]       out_data;
	logic              append_valid;
	logic [31:0]       append_addr;
	logic [31:0]       append_data;
	logic              pattern_hit;
	logic [7:0]        start_take;
	logic [7:0]        abort_take;
	logic [7:0]        channel_enable;
	logic [15:0]       channel_priority;
	logic              grant_valid;
	logic [2:0]        grant_channel;
	logic [7:0]        write_count;
	logic [31:0]       app_addr;
	logic [31:0]       app_data;
	int                n_fail          = 0;
	int                compares        = 0;
	int                cycles          = 0;

	dma_crc_chan dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.err_read_valid(err_read_valid), .err_read_addr(err_read_addr), .err_write_valid(err_write_valid),
		.err_write_addr(err_write_addr), .beat_valid(beat_valid), .beat_channel(beat_channel),
		.beat_data(beat_data), .beat_last(beat_last), .beat_dest_addr(DEST), .beat_pattern_en(beat_pattern_en),
		.beat_pattern(beat_pattern), .out_valid(out_valid), .out_write(out_write), .out_data(out_data),
		.append_valid(append_valid), .append_addr(append_addr), .append_data(append_data),
		.pattern_hit(pattern_hit), .block_done(block_done), .chan_active(chan_active),
		.start_event(start_event), .abort_event(abort_event), .start_take(start_take), .abort_take(abort_take),
		.channel_enable(channel_enable), .channel_priority(channel_priority), .chan_request(chan_request),
		.grant_valid(grant_valid), .grant_channel(grant_channel));

	dest_memory partner (.clk(clk), .rst_n(rst_n), .out_valid(out_valid), .out_write(out_write),
		.out_data(out_data), .append_valid(append_valid), .append_addr(append_addr),
		.append_data(append_data), .write_count(write_count), .last_word(), .app_addr(app_addr),
		.app_data(app_data));

	always #10 clk = ~clk;

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			n_fail++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic logic [31:0] crc_ref(input logic [31:0] r, input logic [31:0] d, input logic [4:0] pl,
		input logic refl);
		logic [31:0] m;
		logic        fb;
		m = 32'hFFFF_FFFF >> (5'd31 - pl);
		for (int i = 0; i < 32; i++)
		begin
			fb = r[pl] ^ (refl ? d[i] : d[31 - i]);
			r = ((r << 1) ^ (TAPS & {32{fb}})) & m;
		end
		return r;
	endfunction

	function automatic logic [31:0] reorder(input logic [31:0] d, input logic [1:0] o);
		case (o)
			2'h1: return {d[7:0], d[15:8], d[23:16], d[31:24]};
			2'h2: return {d[15:0], d[31:16]};
			2'h3: return {d[23:16], d[31:24], d[7:0], d[15:8]};
			default: return d;
		endcase
	endfunction

	function automatic logic [15:0] ip_add(input logic [15:0] s, input logic [15:0] h);
		logic [16:0] t;
		t = {1'b0, s} + {1'b0, h};
		return t[15:0] + {15'h0, t[16]};
	endfunction

	task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask

	task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
		logic [31:0] v;
		reg_rd(a, v);
		check($sformatf("register %h", a), v, e);
	endtask

	task automatic beat(input logic [2:0] ch, input logic [31:0] d, input logic last);
		@(posedge clk);
		beat_valid <= 1'b1;
		beat_channel <= ch;
		beat_data <= d;
		beat_last <= last;
		@(posedge clk);
		beat_valid <= 1'b0;
		beat_last <= 1'b0;
		#1;
	endtask

	task automatic pulse(input int s, input logic [7:0] m);
		@(posedge clk);
		case (s)
			0: block_done <= m;
			1: start_event <= m;
			default: abort_event <= m;
		endcase
		@(posedge clk);
		block_done <= '0;
		start_event <= '0;
		abort_event <= '0;
		#1;
	endtask

	task automatic grant(input logic [7:0] r, input logic [3:0] e);
		@(posedge clk);
		chan_request <= r;
		@(posedge clk);
		#1;
		check("grant", {grant_valid, grant_channel}, e);
	endtask

	task automatic reset_values;
		rd_chk(ERR_ADDR_OFS, ERR_ADDR_RESET);
		rd_chk(CRC_CTRL_OFS, CRC_CTRL_RESET);
		rd_chk(CRC_VALUE_OFS, CRC_VALUE_RESET);
		rd_chk(CRC_TAPS_OFS, CRC_TAPS_RESET);
		for (int i = 0; i < CHANNELS; i++)
			rd_chk(8'h40 + 8'(i * 16), CHAN_CTRL_RESET);
		reg_wr(8'hF0, 32'hFFFF_FFFF);
		rd_chk(8'hF0, 32'h0);
	endtask

	task automatic err_capture;
		@(posedge clk);
		err_read_valid <= 1'b1;
		err_write_valid <= 1'b1;
		@(posedge clk);
		err_read_valid <= 1'b0;
		err_write_addr <= 32'hC000_0030;
		@(posedge clk);
		err_write_valid <= 1'b0;
		rd_chk(ERR_ADDR_OFS, 32'hA000_0010);
		rd_chk(ERR_ADDR_OFS, 32'h0);
		@(posedge clk);
		err_write_valid <= 1'b1;
		@(posedge clk);
		err_write_valid <= 1'b0;
		rd_chk(ERR_ALIAS_OFS, 32'hC000_0030);
		rd_chk(ERR_ADDR_OFS, 32'h0);
	endtask

	task automatic crc_orders;
		logic [1:0]  o;
		logic        w;
		logic        f;
		logic [31:0] x;
		logic [31:0] e;
		reg_wr(CRC_TAPS_OFS, TAPS);
		rd_chk(CRC_TAPS_OFS, TAPS);
		for (int k = 0; k < 8; k++)
		begin
			o = 2'(k);
			w = k[2];
			f = k[1] ^ k[2];
			x = reorder(D, o);
			reg_wr(CRC_CTRL_OFS, {2'b00, o, w, 2'b00, f, 11'h000, 5'd7, 8'h83});
			reg_wr(CRC_VALUE_OFS, 32'h1234_56FF);
			rd_chk(CRC_VALUE_OFS, 32'h0000_00FF);
			beat(3'd2, D, 1'b0);
			check("other channel", out_data, D);
			beat(3'd3, D, 1'b0);
			check("dest word", out_data, w ? x : D);
			e = crc_ref(32'hFF, x, 5'd7, f);
			rd_chk(CRC_VALUE_OFS, e);
		end
		for (int c = 0; c < 8; c++)
		begin
			reg_wr(CRC_CTRL_OFS, 32'h0000_0780 | c);
			reg_wr(CRC_VALUE_OFS, 32'h0);
			beat(3'(c), D, 1'b0);
			rd_chk(CRC_VALUE_OFS, crc_ref(32'h0, D, 5'd7, 1'b0));
		end
		reg_wr(CRC_CTRL_OFS, 32'h1800_0703);
		beat(3'd3, D, 1'b0);
		check("engine off", out_data, D);
		rd_chk(CRC_VALUE_OFS, crc_ref(32'h0, D, 5'd7, 1'b0));
	endtask

	task automatic ip_sum;
		reg_wr(CRC_CTRL_OFS, 32'h0000_03A3);
		reg_wr(CRC_VALUE_OFS, 32'hFFFF_1234);
		rd_chk(CRC_VALUE_OFS, 32'h0000_1234);
		beat(3'd3, 32'h0001_F000, 1'b0);
		rd_chk(CRC_VALUE_OFS, {16'h0, ~ip_add(ip_add(~16'h1234, 16'h0001), 16'hF000)});
		// Reflected halves: 0x0001 enters as 0x8000 and 0x8000 as 0x0001, so the sum is 0x8001.
		reg_wr(CRC_CTRL_OFS, 32'h0100_03A3);
		reg_wr(CRC_VALUE_OFS, 32'h0000_FFFF);
		beat(3'd3, 32'h0001_8000, 1'b0);
		rd_chk(CRC_VALUE_OFS, 32'h0000_7FFE);
	endtask

	task automatic append_run;
		logic [31:0] e;
		logic [7:0]  wc;
		reg_wr(CRC_CTRL_OFS, 32'h0800_07C3);
		rd_chk(CRC_CTRL_OFS, 32'h0800_0783);
		reg_wr(CRC_CTRL_OFS, 32'h0000_07C3);
		reg_wr(CRC_VALUE_OFS, 32'h0);
		wc = write_count;
		beat(3'd3, D, 1'b0);
		check("append early", {out_valid, out_write, append_valid}, 3'b100);
		beat(3'd3, 32'hCAFE_0001, 1'b1);
		e = crc_ref(crc_ref(32'h0, D, 5'd7, 1'b0), 32'hCAFE_0001, 5'd7, 1'b0);
		check("append strobe", {out_write, append_valid}, 2'b01);
		@(posedge clk);
		#1;
		check("append addr", app_addr, DEST);
		check("append data", app_data, e);
		check("dest writes", write_count, wc);
	endtask

	task automatic pattern_run;
		@(posedge clk);
		beat_pattern_en <= 1'b1;
		reg_wr(8'h60, 32'h7700_2880);
		beat(3'd2, 32'h0000_7755, 1'b0);
		check("ignored byte hit", pattern_hit, 1'b1);
		@(posedge clk);
		#1;
		check("hit clears enable", channel_enable[2], 1'b0);
		beat(3'd2, 32'h0000_7655, 1'b0);
		check("byte mismatch", pattern_hit, 1'b0);
		reg_wr(8'h60, 32'h7700_0800);
		beat(3'd2, 32'h0000_7755, 1'b0);
		check("ignore off", pattern_hit, 1'b0);
		reg_wr(8'h60, 32'h0000_0000);
		beat(3'd2, 32'h0000_7755, 1'b0);
		check("one byte", pattern_hit, 1'b1);
		@(posedge clk);
		beat_pattern_en <= 1'b0;
	endtask

	task automatic channel_run;
		logic [31:0] v;
		reg_wr(8'h40, 32'h0000_0080);
		rd_chk(8'h40, 32'h0000_8080);
		reg_wr(8'h50, 32'h0000_0020);
		reg_wr(8'h60, 32'h0000_0090);
		reg_wr(8'h70, 32'h0000_0120);
		pulse(0, 8'h01);
		check("after first done", channel_enable, 8'h06);
		pulse(0, 8'h14);
		check("after second done", channel_enable, 8'h0E);
		@(posedge clk);
		chan_active <= 8'h02;
		reg_wr(8'h50, 32'h0);
		reg_rd(8'h50, v);
		check("busy while active", v, 32'h0000_8000);
		@(posedge clk);
		chan_active <= 8'h00;
		for (int i = 0; i < 8 && v[15] !== 1'b0; i++)
			reg_rd(8'h50, v);
		check("busy after idle", v, 32'h0);
		pulse(1, 8'h20);
		check("start ignored", start_take, 8'h00);
		reg_wr(8'h90, 32'h0000_0040);
		pulse(2, 8'h20);
		check("abort taken", abort_take, 8'h20);
		rd_chk(8'h90, 32'h0000_0044);
		reg_wr(8'hA0, 32'h0000_0081);
		reg_wr(8'hB0, 32'h0000_0083);
		check("priorities", channel_priority[15:12], 4'hD);
		grant(8'hCC, 4'hF);
		grant(8'h4C, 4'hE);
		grant(8'h0C, 4'hA);
	endtask

	initial
	begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		reset_values();
		err_capture();
		crc_orders();
		ip_sum();
		append_run();
		pattern_run();
		channel_run();
		tally_and_finish();
	end
endmodule
`default_nettype wire
